// [rtl/clock_source_select.sv]
`timescale 1ns/1ps
`include "measure_timer_cfg.svh"

// ----------------------------------------
// Counter tick generator
// ----------------------------------------
module clock_source_select
  import measure_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_enable,
  input wire clock_source_t i_sel,
  input wire logic i_hs_tick,
  input wire logic i_sub_tick,
  input wire logic i_ext_rise,
  input wire logic i_ext_fall,
  output logic o_tick
);

  logic [1:0] sys_div; // System clock prescaler
  logic [5:0] hs_div; // High speed prescaler

  // Dividers held at zero while off, which saves power
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sys_div <= 2'h0;
      hs_div <= 6'h00;
    end else if (!i_enable) begin
      sys_div <= 2'h0;
      hs_div <= 6'h00;
    end else begin
      sys_div <= sys_div + 2'h1;
      if (i_hs_tick) begin
        hs_div <= hs_div + 6'h01;
      end
    end
  end

  // Source decode
  always_comb begin
    unique case (i_sel)
      CLK_SYS_DIV4: o_tick = (sys_div == `SYS_DIV);
      CLK_SYS: o_tick = 1'b1;
      // Low four prescaler bits all set marks every 16th tick
      CLK_HS_DIV16: o_tick = i_hs_tick && ((hs_div & `HS_DIV16) == `HS_DIV16);
      CLK_HS_DIV64: o_tick = i_hs_tick && (hs_div == `HS_DIV64);
      CLK_SUB_A, CLK_SUB_B: o_tick = i_sub_tick;
      CLK_EXT_RISE: o_tick = i_ext_rise;
      CLK_EXT_FALL: o_tick = i_ext_fall;
    endcase
  end

endmodule // clock_source_select

// [rtl/measure_timer_cfg.svh]
`ifndef MEASURE_TIMER_CFG_SVH
`define MEASURE_TIMER_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CLOCK_WINDOW_CONTROL 8'h00
`define OFS_MODE_EDGE_CONTROL 8'h04
`define OFS_COUNTER_VALUE_LOW 8'h08
`define OFS_COUNTER_VALUE_HIGH 8'h0c
`define OFS_CAPTURE_RESULT_LOW 8'h10
`define OFS_CAPTURE_RESULT_HIGH 8'h14
`define OFS_EVENT_STATUS 8'h18
`define OFS_EVENT_MASK 8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLK_SEL_MSB 6
`define CLK_SEL_LSB 4
`define RUN_BIT 3
`define WIN_SEL_MSB 2
`define WIN_SEL_LSB 0
`define MODE_MSB 7
`define MODE_LSB 6
`define EDGE_MSB 5
`define EDGE_LSB 4
`define EVT_WINDOW_BIT 0
`define EVT_CAPTURE_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CLOCK_WINDOW_RESET 8'h00
`define MODE_EDGE_RESET 8'h00
`define EVENT_MASK_RESET 2'h0

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define SYS_DIV 2'h3
`define HS_DIV16 6'h0f
`define HS_DIV64 6'h3f
`define WINDOW_BASE_PERIODS 21'h002000

`endif

// [rtl/measure_timer_pkg.sv]
package measure_timer_pkg;

  // Counter clock source codes
  typedef enum logic [2:0] {
    CLK_SYS_DIV4 = 3'h0,
    CLK_SYS = 3'h1,
    CLK_HS_DIV16 = 3'h2,
    CLK_HS_DIV64 = 3'h3,
    CLK_SUB_A = 3'h4,
    CLK_SUB_B = 3'h5,
    CLK_EXT_RISE = 3'h6,
    CLK_EXT_FALL = 3'h7
  } clock_source_t;

  // Capture edge codes
  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_OFF = 2'h3
  } capture_edge_t;

  // Ten-bit count value
  typedef logic [9:0] count_t;

endpackage

// [rtl/phase_period_capture_timer.sv]
`timescale 1ns/1ps
`include "measure_timer_cfg.svh"

// ----------------------------------------
// Phase / period capture timer
// ----------------------------------------
// Behaviour
// - Three-bit field picks the counter clock
// - Run bit counts; clear stops, powers down
// - Run rising clears counter and result
// - Run falling holds counter and result
// - Window is 8192 periods doubled per code
// - Window end copies counter, sets flag
// - Mode 0x capture, 1x timer/counter
// - Edge field: rise, fall, both, off
// - Timer mode ignores the edge field
// - Live count readable as low/high registers
// - Result readable as low/high registers
// - Unused register bits read zero
module phase_period_capture_timer
  import measure_timer_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_PHASE,
  input wire logic I_EXTERNAL_COUNT_CLOCK,
  input wire logic I_HIGH_SPEED_TICK,
  input wire logic I_SUB_TICK,
  input wire logic I_PWM_TICK,
  output logic O_IRQ
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] timer_clock_window_control; // Clock, run, window
  logic [7:0] timer_mode_edge_control; // Mode and edge
  logic [1:0] event_status; // Sticky events
  logic [1:0] event_mask; // Interrupt enables
  count_t counter; // Live count
  count_t capture_result; // Held count
  logic run_q; // Run bit one cycle ago
  logic run_rise; // Run bit went high
  logic counter_run; // Run bit
  clock_source_t counter_clock_select; // Clock source code
  logic [2:0] window_length_select; // Window code
  logic [1:0] operating_mode_select; // Mode code
  capture_edge_t capture_edge_select; // Edge code
  logic timer_mode; // Timer/counter mode active
  logic count_tick; // Counter advance strobe
  logic window_elapsed; // Window end strobe
  logic edge_hit; // Selected phase edge seen
  logic capture_fire; // Copy counter now
  logic phase_s1; // Phase sync, first stage
  logic phase_s2; // Phase sync, second stage
  logic phase_s3; // Phase history for edges
  logic ext_s1; // Count clock sync, first stage
  logic ext_s2; // Count clock sync, second stage
  logic ext_s3; // Count clock history
  logic ext_rise; // Count clock rising edge
  logic ext_fall; // Count clock falling edge
  logic phase_rise; // Phase rising edge
  logic phase_fall; // Phase falling edge
  logic setup; // APB setup cycle
  logic access; // APB access cycle
  logic wr_en; // Write takes effect
  logic mapped; // Address decodes to a register
  logic [1:0] event_set; // Events this cycle
  logic [1:0] event_clear; // Write-one-to-clear
  logic [31:0] next_prdata; // Read data for this address

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  assign counter_run = timer_clock_window_control[`RUN_BIT];
  assign counter_clock_select =
    clock_source_t'(timer_clock_window_control[`CLK_SEL_MSB:`CLK_SEL_LSB]);
  assign window_length_select =
    timer_clock_window_control[`WIN_SEL_MSB:`WIN_SEL_LSB];
  assign operating_mode_select =
    timer_mode_edge_control[`MODE_MSB:`MODE_LSB];
  assign capture_edge_select =
    capture_edge_t'(timer_mode_edge_control[`EDGE_MSB:`EDGE_LSB]);

  // Only the upper mode bit matters
  assign timer_mode = operating_mode_select[1];

  // ----------------------------------------
  // Edge decode helper
  // ----------------------------------------
  // Shared decode of an edge code against seen edges
  function automatic logic edge_match(input capture_edge_t sel,
                                      input logic rise,
                                      input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_BOTH: hit = rise | fall;
      EDGE_OFF: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Both pins are asynchronous; two stages before use
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      phase_s1 <= 1'b0;
      phase_s2 <= 1'b0;
      phase_s3 <= 1'b0;
    end else begin
      phase_s1 <= I_PHASE;
      phase_s2 <= phase_s1;
      phase_s3 <= phase_s2;
    end
  end

  // External count clock, same treatment
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= I_EXTERNAL_COUNT_CLOCK;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Edges seen only from settled stages
  assign phase_rise = phase_s2 & ~phase_s3;
  assign phase_fall = ~phase_s2 & phase_s3;
  // Count clock must stay below a quarter of I_CLK
  assign ext_rise = ext_s2 & ~ext_s3;
  assign ext_fall = ~ext_s2 & ext_s3;

  // ----------------------------------------
  // Counter clock and window
  // ----------------------------------------
  // Prescalers stop while the run bit is low
  clock_source_select u_clock_source_select (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_enable(counter_run),
    .i_sel(counter_clock_select),
    .i_hs_tick(I_HIGH_SPEED_TICK),
    .i_sub_tick(I_SUB_TICK),
    .i_ext_rise(ext_rise),
    .i_ext_fall(ext_fall),
    .o_tick(count_tick)
  );

  // Window runs only in timer/counter mode
  window_timer u_window_timer (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_run(counter_run && timer_mode),
    .i_restart(run_rise),
    .i_len_sel(window_length_select),
    .i_pwm_tick(I_PWM_TICK),
    .o_elapsed(window_elapsed)
  );

  // ----------------------------------------
  // Run edge tracking
  // ----------------------------------------
  // History of the run bit
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      run_q <= 1'b0;
    end else begin
      run_q <= counter_run;
    end
  end

  assign run_rise = counter_run & ~run_q;

  // ----------------------------------------
  // Count and capture
  // ----------------------------------------
  // Edge field only consulted in capture mode
  assign edge_hit = timer_mode ? 1'b0 :
    edge_match(capture_edge_select, phase_rise, phase_fall);

  // Source of the copy depends on the mode
  assign capture_fire = counter_run && !run_rise &&
    (timer_mode ? window_elapsed : edge_hit);

  // Live counter; wraps at ten bits
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      counter <= 10'h000;
    end else if (run_rise) begin
      // Fresh start on every turn-on
      counter <= 10'h000;
    end else if (counter_run && count_tick) begin
      counter <= counter + 10'h001;
    end
    // Otherwise the residual value stays
  end

  // Capture result register
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      capture_result <= 10'h000;
    end else if (run_rise) begin
      capture_result <= 10'h000;
    end else if (capture_fire) begin
      // Value before this cycle's increment
      capture_result <= counter;
    end
    // Held while stopped
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // No wait states; every access ends in one cycle
  assign setup = I_PSEL && !I_PENABLE;
  assign access = I_PSEL && I_PENABLE;
  assign wr_en = access && I_PWRITE;
  assign O_PREADY = 1'b1;

  // Address decode
  always_comb begin
    unique case (I_PADDR)
      `OFS_CLOCK_WINDOW_CONTROL,
      `OFS_MODE_EDGE_CONTROL,
      `OFS_COUNTER_VALUE_LOW,
      `OFS_COUNTER_VALUE_HIGH,
      `OFS_CAPTURE_RESULT_LOW,
      `OFS_CAPTURE_RESULT_HIGH,
      `OFS_EVENT_STATUS,
      `OFS_EVENT_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Unmapped addresses answer with an error
  assign O_PSLVERR = access && !mapped;

  // Read mux; unused bits padded with zeros
  always_comb begin
    next_prdata = 32'h00000000;
    unique case (I_PADDR)
      `OFS_CLOCK_WINDOW_CONTROL:
        next_prdata = {25'h0000000, timer_clock_window_control[6:0]};
      `OFS_MODE_EDGE_CONTROL:
        next_prdata = {24'h000000, timer_mode_edge_control[7:4], 4'h0};
      `OFS_COUNTER_VALUE_LOW:
        next_prdata = {24'h000000, counter[7:0]};
      `OFS_COUNTER_VALUE_HIGH:
        next_prdata = {30'h00000000, counter[9:8]};
      `OFS_CAPTURE_RESULT_LOW:
        next_prdata = {24'h000000, capture_result[7:0]};
      `OFS_CAPTURE_RESULT_HIGH:
        next_prdata = {30'h00000000, capture_result[9:8]};
      `OFS_EVENT_STATUS:
        next_prdata = {30'h00000000, event_status};
      `OFS_EVENT_MASK:
        next_prdata = {30'h00000000, event_mask};
      default:
        next_prdata = 32'h00000000;
    endcase
  end

  // Read data caught in the setup cycle, so it is
  // a flop output and stable through the access
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PRDATA <= 32'h00000000;
    end else if (setup && !I_PWRITE) begin
      O_PRDATA <= next_prdata;
    end
  end

  // Control registers; read-only offsets ignore writes
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      timer_clock_window_control <= `CLOCK_WINDOW_RESET;
      timer_mode_edge_control <= `MODE_EDGE_RESET;
      event_mask <= `EVENT_MASK_RESET;
    end else if (wr_en) begin
      if (I_PADDR == `OFS_CLOCK_WINDOW_CONTROL) begin
        // Bit 7 is not stored
        timer_clock_window_control <= {1'b0, I_PWDATA[6:0]};
      end
      if (I_PADDR == `OFS_MODE_EDGE_CONTROL) begin
        // Low nibble is not stored
        timer_mode_edge_control <= {I_PWDATA[7:4], 4'h0};
      end
      if (I_PADDR == `OFS_EVENT_MASK) begin
        event_mask <= I_PWDATA[1:0];
      end
    end
  end

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  // Window flag in timer mode, capture flag otherwise
  always_comb begin
    event_set = 2'h0;
    event_set[`EVT_WINDOW_BIT] = capture_fire && timer_mode;
    event_set[`EVT_CAPTURE_BIT] = capture_fire && !timer_mode;
  end

  // Write of one clears a bit
  assign event_clear = (wr_en && I_PADDR == `OFS_EVENT_STATUS) ?
    I_PWDATA[1:0] : 2'h0;

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      event_status <= 2'h0;
    end else begin
      event_status <= (event_status & ~event_clear) | event_set;
    end
  end

  // Level interrupt, registered for a clean output
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(event_status & event_mask);
    end
  end

endmodule // phase_period_capture_timer

// [rtl/window_timer.sv]
`timescale 1ns/1ps
`include "measure_timer_cfg.svh"

// ----------------------------------------
// Measurement window timer
// ----------------------------------------
module window_timer (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic [2:0] i_len_sel,
  input wire logic i_pwm_tick,
  output logic o_elapsed
);

  logic [19:0] periods; // Elapsed PWM clock periods
  logic [20:0] length; // Window length in periods
  logic last; // Final period of the window

  // Base length doubled per code step
  assign length = `WINDOW_BASE_PERIODS << i_len_sel;
  assign last = i_pwm_tick && ({1'b0, periods} == length - 21'h000001);
  assign o_elapsed = i_run && last;

  // Period counter, frozen while stopped
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      periods <= 20'h00000;
    end else if (i_restart) begin
      periods <= 20'h00000;
    end else if (i_run && i_pwm_tick) begin
      // A shorter code picked past its end restarts at once, with no o_elapsed
      if ({1'b0, periods} >= length - 21'h000001) begin
        periods <= 20'h00000;
      end else begin
        periods <= periods + 20'h00001;
      end
    end
  end

endmodule // window_timer

// [testbench/capture_timer_assertions.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the capture timer
// ----------------------------------------
module capture_timer_checker (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Access phase qualifiers
  logic acc;
  logic rd;
  logic wr;
  logic [6:0] ctrl_shadow; // Last control word written
  logic mask_shadow; // Any mask bit written high
  assign acc = I_PSEL && I_PENABLE;
  assign rd = acc && !I_PWRITE;
  assign wr = acc && I_PWRITE;
  // Shadows follow every access-phase write; PREADY is not consulted
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_shadow <= 7'h00;
      mask_shadow <= 1'b0;
    end else if (wr && I_PADDR == 8'h00) begin
      ctrl_shadow <= I_PWDATA[6:0];
    end else if (wr && I_PADDR == 8'h1c) begin
      mask_shadow <= |I_PWDATA[1:0];
    end
  end
  ctrl_readback_a: assert property (rd && I_PADDR == 8'h00 |-> O_PRDATA == {25'h0, ctrl_shadow})
    else $error("control word readback wrong");
  mode_unused_zero_a: assert property (rd && I_PADDR == 8'h04 |-> O_PRDATA[31:8] == 0 && O_PRDATA[3:0] == 0)
    else $error("mode register unused bits set");
  count_low_width_a: assert property (rd && I_PADDR == 8'h08 |-> O_PRDATA[31:8] == 0)
    else $error("count low byte too wide");
  count_high_zero_a: assert property (rd && I_PADDR == 8'h0c |-> O_PRDATA[31:2] == 0)
    else $error("count high unused bits set");
  result_low_width_a: assert property (rd && I_PADDR == 8'h10 |-> O_PRDATA[31:8] == 0)
    else $error("result low byte too wide");
  result_high_zero_a: assert property (rd && I_PADDR == 8'h14 |-> O_PRDATA[31:2] == 0)
    else $error("result high unused bits set");
  unmapped_error_a: assert property (rd && I_PADDR >= 8'h20 |-> O_PSLVERR && O_PRDATA == 0)
    else $error("unmapped read not refused");
  mapped_no_error_a: assert property (acc && I_PADDR <= 8'h1c && I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR)
    else $error("mapped access refused");
  idle_no_error_a: assert property (!acc |-> !O_PSLVERR && O_PREADY)
    else $error("error outside access");
  masked_irq_low_a: assert property (!mask_shadow |=> !O_IRQ)
    else $error("interrupt while fully masked");
  cover property (rd && I_PADDR == 8'h18 && O_PRDATA[0]);
  cover property (rd && I_PADDR == 8'h18 && O_PRDATA[1]);
  cover property ($rose(O_IRQ));
endmodule // capture_timer_checker

// [testbench/phase_sense_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Phase comparator and count clock source
// ----------------------------------------
module phase_sense_model (
  input wire logic i_clk,
  input wire logic i_level,
  input wire logic i_ext_run,
  output logic o_phase,
  output logic o_ext_clk
);
  logic [1:0] div = 2'h0; // Four cycles a level, well over the sync minimum
  initial o_phase = 1'b0;
  initial o_ext_clk = 1'b0;
  // Comparator output follows the commanded level one edge late
  always @(posedge i_clk) o_phase <= i_level;
  // Count clock stands still low outside bursts
  always @(posedge i_clk) begin
    div <= i_ext_run ? div + 2'h1 : 2'h0;
    if (!i_ext_run) o_ext_clk <= 1'b0;
    else if (div == 2'h3) o_ext_clk <= ~o_ext_clk;
  end
endmodule // phase_sense_model

// [testbench/test_phase_period_capture_timer.sv]
`timescale 1ns/1ps
bind phase_period_capture_timer capture_timer_checker u_chk (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ));
// ----------------------------------------
// Bench top
// ----------------------------------------
module test_phase_period_capture_timer;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic hs_tick = 1'b0;
  logic sub_tick = 1'b0;
  logic pwm_tick = 1'b0;
  logic level = 1'b0; // Commanded comparator level
  logic ext_run = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, phase, ext_clk;
  logic [31:0] q;
  logic err;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int div[8] = '{4, 1, 16, 64, 1, 1, 8, 8}; // Ticks per count, by source code
  int exp_q[$]; // Expected capture results, rise then fall
  phase_period_capture_timer u_dut (.I_CLK(clk), .I_RESET_N(reset_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_PHASE(phase), .I_EXTERNAL_COUNT_CLOCK(ext_clk), .I_HIGH_SPEED_TICK(hs_tick),
    .I_SUB_TICK(sub_tick), .I_PWM_TICK(pwm_tick), .O_IRQ(irq));
  phase_sense_model u_far (.i_clk(clk), .i_level(level), .i_ext_run(ext_run), .o_phase(phase), .o_ext_clk(ext_clk));
  always #50 clk = ~clk;
  // Hang guard, well above the two long windows
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Counts whose exact phase against the bus is not fixed
  task automatic chk_near(input string what, input int exp, input logic [31:0] got, input int tol);
    num_checks++;
    if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // One transfer; waits for ready with no assumed latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("write error", 32'h0, {31'h0, err});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      sub_tick <= 1'b1;
      @(posedge clk);
      sub_tick <= 1'b0;
    end
  endtask
  initial begin
    logic [31:0] v;
    int k;
    int t0;
    v = $urandom(32'hcc5d);
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, read-only and unmapped places
    for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0, "reset value");
    wr(8'h08, $urandom);
    rd(8'h08, 32'h0, "read-only count");
    apb(1'b1, 8'h20, 32'hffff);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped read error", 32'h1, {31'h0, err});
    chk("unmapped read data", 32'h0, q);
    repeat (4) begin
      v = $urandom & 32'hfffffff7; // Run stays off here
      wr(8'h00, v);
      rd(8'h00, v & 32'h77, "clock window control");
      v = $urandom;
      wr(8'h04, v);
      rd(8'h04, v & 32'hf0, "mode edge control");
    end
    $display("test registers done");
    // Every clock source over a fixed span; run rise restarts from zero
    wr(8'h04, 32'h30);
    hs_tick <= 1'b1;
    sub_tick <= 1'b1;
    ext_run <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(8'h00, 32'(s << 4) | 32'h8);
      repeat (256) @(posedge clk);
      wr(8'h00, 32'(s << 4));
      apb(1'b0, 8'h08, 32'h0);
      v = q;
      apb(1'b0, 8'h0c, 32'h0);
      chk_near("counted ticks", 256 / div[s], {q[23:0], v[7:0]}, 4);
    end
    hs_tick <= 1'b0;
    sub_tick <= 1'b0;
    ext_run <= 1'b0;
    $display("test clock sources done");
    // Window length, capture at its end, interrupt and hold on stop
    wr(8'h1c, 32'h1);
    wr(8'h04, 32'h80);
    pwm_tick <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      k = $urandom_range(40, 5);
      wr(8'h00, 32'h48 | w);
      t0 = cycles;
      ticks(k);
      while (irq !== 1'b1 && cycles - t0 < 20000) @(posedge clk);
      chk_near("window length", 8192 << w, cycles - t0, 4);
      rd(8'h10, k, "window result");
      rd(8'h18, 32'h1, "window flag");
      wr(8'h1c, 32'h0);
      repeat (2) @(posedge clk);
      chk("masked irq", 32'h0, {31'h0, irq});
      wr(8'h1c, 32'h1);
      repeat (2) @(posedge clk);
      chk("unmasked irq", 32'h1, {31'h0, irq});
      wr(8'h18, 32'h1);
      repeat (2) @(posedge clk);
      chk("cleared irq", 32'h0, {31'h0, irq});
      wr(8'h00, 32'h40 | w);
      ticks(3);
      rd(8'h08, k, "held count");
      rd(8'h10, k, "held result");
    end
    wr(8'h00, 32'h48);
    rd(8'h10, 32'h0, "result after restart");
    pwm_tick <= 1'b0;
    $display("test window done");
    // Capture edges; code four is timer mode with the rising edge chosen
    wr(8'h1c, 32'h2);
    for (int e = 0; e < 5; e++) begin
      k = $urandom_range(9, 2);
      exp_q.push_back((e == 0 || e == 2) ? k : 0);
      exp_q.push_back(e == 0 ? k : ((e == 1 || e == 2) ? k + 1 : 0));
      wr(8'h04, e < 4 ? 32'((e << 4) | ((e & 1) << 6)) : 32'hc0);
      wr(8'h00, 32'h48);
      ticks(k);
      level <= 1'b1;
      repeat (6) @(posedge clk);
      rd(8'h10, exp_q.pop_front(), "rise capture");
      ticks(1);
      level <= 1'b0;
      repeat (6) @(posedge clk);
      rd(8'h10, exp_q.pop_front(), "fall capture");
      chk("capture irq", (e < 3) ? 32'h1 : 32'h0, {31'h0, irq});
      rd(8'h18, (e < 3) ? 32'h2 : 32'h0, "capture flag");
      wr(8'h18, 32'h3);
      wr(8'h00, 32'h40);
    end
    $display("test capture done");
    finish_test();
  end
endmodule // test_phase_period_capture_timer
